// ### src/rsc_reset_source_controller.sv
// reset source controller: request gathering, cause flags, sfr port
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller #(
    parameter int unsigned CLOCK_LOSS_CYCLES = rsc_pkg::CLOCK_LOSS_CYCLES,
    parameter int unsigned WDT_LIMIT = rsc_pkg::WDT_LIMIT_DFLT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic supply_above_i,
    input wire logic comparator_out_i,
    input wire logic monitored_clock_i,
    input wire logic wdt_kick_i,
    input wire logic wdt_disable_i,
    input wire rsc_pkg::rsc_flash_req_t flash_req_i,
    input wire rsc_pkg::rsc_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sys_reset_o,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    output logic supply_monitor_enable_o
);
    typedef struct packed {
        rsc_pkg::rsc_state_t st;
        logic [rsc_pkg::HOLD_W-1:0] hold_cnt;
        rsc_pkg::rsc_cause_t cause;
        rsc_pkg::rsc_cause_t flags;
        logic supply_monitor_enable;
        logic supply_reset_select;
        logic clock_loss_enable;
        logic comparator_reset_enable;
        logic sys_reset;
        logic pin_oe;
        logic [7:0] rdata;
    } rsc_main_st_t;

    localparam logic [rsc_pkg::HOLD_W-1:0] HOLD_LAST =
        rsc_pkg::HOLD_W'(rsc_pkg::RESET_HOLD_CYCLES - 1);
    // power-on leaves only the power flag standing
    localparam rsc_pkg::rsc_cause_t POR_CAUSE = '{
        flash: 1'b0,
        comparator: 1'b0,
        software: 1'b0,
        watchdog: 1'b0,
        clock_loss: 1'b0,
        power: 1'b1,
        pin: 1'b0
    };
    localparam int unsigned ADDR_CHECKS = 3;

    rsc_main_st_t q;
    rsc_main_st_t d;
    rsc_pkg::rsc_cause_t req;
    logic level_req;
    logic wr_ctrl;
    logic wr_cause;
    logic flash_err;
    logic [ADDR_CHECKS-1:0] addr_strobe;
    logic [ADDR_CHECKS-1:0][15:0] addr_vec;
    logic [ADDR_CHECKS-1:0] addr_high;
    rsc_pkg::rsc_cause_t merge_mask;
    logic clock_loss_timeout;
    logic wdt_expire;
    logic sub_rst;

    // helpers reset together with the system so they restart clean
    assign sub_rst = rst_i || q.sys_reset;

    rsc_clock_loss #(
        .LIMIT(CLOCK_LOSS_CYCLES)
    ) u_clock_loss (
        .clk_i(clk_i),
        .rst_i(sub_rst),
        .enable_i(q.clock_loss_enable),
        .mon_clk_i(monitored_clock_i),
        .timeout_o(clock_loss_timeout)
    );

    rsc_watchdog #(
        .LIMIT(WDT_LIMIT)
    ) u_watchdog (
        .clk_i(clk_i),
        .rst_i(sub_rst),
        .kick_i(wdt_kick_i),
        .disable_i(wdt_disable_i),
        .expire_o(wdt_expire)
    );

    assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == rsc_pkg::SUPPLY_MON_CTRL_ADDR);
    assign wr_cause = sfr_req_i.wr && (sfr_req_i.addr == rsc_pkg::RESET_CAUSE_ADDR);

    assign addr_strobe = {flash_req_i.fetch, flash_req_i.code_space_read,
        flash_req_i.program_store_write_enable && flash_req_i.data_space_move_wr};
    assign addr_vec = {flash_req_i.fetch_addr, flash_req_i.code_space_addr,
        flash_req_i.data_space_addr};

    // one limit compare per access kind
    for (genvar g = 0; g < ADDR_CHECKS; g++)
    begin : g_addr_check
        assign addr_high[g] = addr_strobe[g] && (addr_vec[g] > rsc_pkg::FLASH_USER_TOP);
    end

    assign flash_err = (|addr_high) || flash_req_i.security_violation;

    always_comb
    begin
        req = '0;
        // pin held low
        // own pull on the shared pin must not read back as an outside reset
        req.pin = !reset_pin_n_i && !q.pin_oe;
        req.power = q.supply_monitor_enable && q.supply_reset_select && !supply_above_i;
        req.clock_loss = clock_loss_timeout;
        req.comparator = q.comparator_reset_enable && !comparator_out_i;
        req.watchdog = wdt_expire;
        req.software = wr_cause && sfr_req_i.wdata[rsc_pkg::RC_SOFTWARE_BIT];
        req.flash = flash_err;
        // level sources keep the device in reset for as long as they stand
        level_req = req.pin || req.power || req.comparator;
        merge_mask = '0;
        merge_mask.pin = 1'b1;
        merge_mask.power = 1'b1;
        merge_mask.comparator = 1'b1;
    end

    always_comb
    begin
        d = q;
        case (q.st)
            rsc_pkg::RSC_RUN:
            begin
                if (wr_ctrl)
                begin
                    d.supply_monitor_enable = sfr_req_i.wdata[rsc_pkg::SMC_ENABLE_BIT];
                end
                if (wr_cause)
                begin
                    d.supply_reset_select = sfr_req_i.wdata[rsc_pkg::RC_POWER_BIT];
                    d.clock_loss_enable = sfr_req_i.wdata[rsc_pkg::RC_CLOCK_LOSS_BIT];
                    d.comparator_reset_enable = sfr_req_i.wdata[rsc_pkg::RC_COMPARATOR_BIT];
                end
                if (|req)
                begin
                    d.st = rsc_pkg::RSC_HOLD;
                    d.cause = req;
                    d.hold_cnt = HOLD_LAST;
                    d.sys_reset = 1'b1;
                    // only supply resets drive the pin
                    d.pin_oe = req.power;
                    d.clock_loss_enable = 1'b0;
                end
            end
            rsc_pkg::RSC_HOLD:
            begin
                d.cause = q.cause | (req & merge_mask);
                d.pin_oe = q.cause.power && (req.power || q.hold_cnt != '0);
                if (level_req)
                begin
                    d.hold_cnt = HOLD_LAST;
                end
                else if (q.hold_cnt == '0)
                begin
                    d.st = rsc_pkg::RSC_RUN;
                    d.sys_reset = 1'b0;
                    d.pin_oe = 1'b0;
                    // cleared only on exit, so a low comparator keeps holding
                    d.comparator_reset_enable = 1'b0;
                    if (q.cause.power)
                    begin
                        d.flags = '0;
                        d.flags.power = 1'b1;
                    end
                    else
                    begin
                        d.flags = q.cause;
                    end
                end
                else
                begin
                    d.hold_cnt = q.hold_cnt - 1'b1;
                end
            end
            default:
            begin
                d.st = rsc_pkg::RSC_RUN;
            end
        endcase

        if (sfr_req_i.rd)
        begin
            if (sfr_req_i.addr == rsc_pkg::SUPPLY_MON_CTRL_ADDR)
            begin
                d.rdata = {q.supply_monitor_enable, supply_above_i,
                           rsc_pkg::SMC_UNUSED_READ};
            end
            else if (sfr_req_i.addr == rsc_pkg::RESET_CAUSE_ADDR)
            begin
                d.rdata = {rsc_pkg::RC_UNUSED_READ, q.flags};
            end
            else
            begin
                d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // power-on: reset held, pin driven low, monitor enabled
            q <= '{
                st: rsc_pkg::RSC_HOLD,
                hold_cnt: HOLD_LAST,
                cause: POR_CAUSE,
                flags: 7'h00,
                supply_monitor_enable: 1'b1,
                supply_reset_select: 1'b1,
                clock_loss_enable: 1'b0,
                comparator_reset_enable: 1'b0,
                sys_reset: 1'b1,
                pin_oe: 1'b1,
                rdata: 8'h00
            };
        end
        else
        begin
            q <= d;
        end
    end

    assign sfr_rdata_o = q.rdata;
    assign sys_reset_o = q.sys_reset;
    // open drain: the pin only ever pulls low
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = q.pin_oe;
    assign supply_monitor_enable_o = q.supply_monitor_enable;
endmodule
`default_nettype wire

// ### src/rsc_pkg.sv
// shared constants and types of the reset source controller
package rsc_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;

    // register addresses on the special-function register port
    localparam logic [7:0] SUPPLY_MON_CTRL_ADDR = 8'hff;
    localparam logic [7:0] RESET_CAUSE_ADDR = 8'hef;

    // supply_monitor_control bit positions
    localparam int unsigned SMC_ENABLE_BIT = 7;
    localparam int unsigned SMC_STATUS_BIT = 6;
    localparam logic [5:0] SMC_UNUSED_READ = 6'h00;

    // reset_cause_register bit positions
    localparam int unsigned RC_PIN_BIT = 0;
    localparam int unsigned RC_POWER_BIT = 1;
    localparam int unsigned RC_CLOCK_LOSS_BIT = 2;
    localparam int unsigned RC_WATCHDOG_BIT = 3;
    localparam int unsigned RC_SOFTWARE_BIT = 4;
    localparam int unsigned RC_COMPARATOR_BIT = 5;
    localparam int unsigned RC_FLASH_BIT = 6;
    localparam logic RC_UNUSED_READ = 1'b0;

    // clock-loss timeout of 100 us
    localparam int unsigned CLOCK_LOSS_US = 100;
    localparam int unsigned CLOCK_LOSS_CYCLES =
        (CLOCK_LOSS_US * 1000 * 1000) / CLK_PERIOD_PS;

    // minimum time the internal reset is held, 100 ns, rounded up
    localparam int unsigned RESET_HOLD_NS = 100;
    localparam int unsigned RESET_HOLD_CYCLES =
        (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned HOLD_W = 8;

    // watchdog clock divider and default overflow count
    localparam int unsigned WDT_DIVIDE = 12;
    localparam int unsigned WDT_LIMIT_DFLT = 256;

    // highest legal user flash address
    localparam logic [15:0] FLASH_USER_TOP = 16'h3dff;

    typedef enum logic [0:0] {
        RSC_RUN = 1'b0,
        RSC_HOLD = 1'b1
    } rsc_state_t;

    // reset cause vector, packed in reset_cause_register bit order 6..0
    typedef struct packed {
        logic flash;
        logic comparator;
        logic software;
        logic watchdog;
        logic clock_loss;
        logic power;
        logic pin;
    } rsc_cause_t;

    typedef struct packed {
        logic program_store_write_enable;
        logic data_space_move_wr;
        logic [15:0] data_space_addr;
        logic code_space_read;
        logic [15:0] code_space_addr;
        logic fetch;
        logic [15:0] fetch_addr;
        logic security_violation;
    } rsc_flash_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsc_sfr_req_t;

endpackage

// ### src/rsc_watchdog.sv
// watchdog counter clocked by the system clock divided by twelve
`timescale 1ns/1ps
`default_nettype none
module rsc_watchdog #(
    parameter int unsigned LIMIT = rsc_pkg::WDT_LIMIT_DFLT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic kick_i,
    input wire logic disable_i,
    output logic expire_o
);
    localparam int unsigned CW = $clog2(LIMIT);
    localparam logic [3:0] DIV_LAST = 4'(rsc_pkg::WDT_DIVIDE - 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LIMIT - 1);

    typedef struct packed {
        logic [3:0] div;
        logic [CW-1:0] cnt;
        logic en;
        logic expire;
    } rsc_wdt_st_t;

    rsc_wdt_st_t q;
    rsc_wdt_st_t d;
    logic tick;

    always_comb
    begin
        d = q;
        tick = (q.div == DIV_LAST);
        d.div = tick ? 4'h0 : q.div + 4'h1;
        d.expire = 1'b0;
        if (disable_i)
        begin
            d.en = 1'b0;
        end
        if (kick_i || !q.en)
        begin
            d.cnt = '0;
        end
        else if (tick)
        begin
            if (q.cnt == CNT_LAST)
            begin
                d.expire = 1'b1;
            end
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '{div: 4'h0, cnt: '0, en: 1'b1, expire: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign expire_o = q.expire;
endmodule
`default_nettype wire

// ### src/rsc_clock_loss.sv
// timer that holds timeout high for as long as the monitored clock has stopped toggling
`timescale 1ns/1ps
`default_nettype none
module rsc_clock_loss #(
    parameter int unsigned LIMIT = rsc_pkg::CLOCK_LOSS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic mon_clk_i,
    output logic timeout_o
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LIMIT);

    typedef struct packed {
        logic prev;
        logic [CW-1:0] cnt;
        logic timeout;
    } rsc_mcd_st_t;

    rsc_mcd_st_t q;
    rsc_mcd_st_t d;

    always_comb
    begin
        d = q;
        d.prev = mon_clk_i;
        d.timeout = 1'b0;
        if (!enable_i || (mon_clk_i != q.prev))
        begin
            d.cnt = '0;
        end
        else if (q.cnt == CNT_LAST)
        begin
            d.timeout = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '{prev: 1'b0, cnt: '0, timeout: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign timeout_o = q.timeout;
endmodule
`default_nettype wire

// ### testbench/rsc_pin_drv.sv
// outside reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_drv (
    input wire logic pull_low_i,
    input wire logic dev_oe_i,
    input wire logic dev_val_i,
    output logic level_o
);
    // outside party or device drive pulls low, pull-up otherwise
    assign level_o = !(pull_low_i || (dev_oe_i && !dev_val_i));
endmodule
`default_nettype wire

// ### testbench/rsc_reset_source_controller_chk.sv
// port-level assertions of the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_chk #(
    parameter int unsigned CLOCK_LOSS_CYCLES = 20,
    parameter int unsigned WDT_LIMIT = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic supply_above_i,
    input wire logic comparator_out_i,
    input wire logic monitored_clock_i,
    input wire logic wdt_kick_i,
    input wire logic wdt_disable_i,
    input wire rsc_pkg::rsc_flash_req_t flash_req_i,
    input wire rsc_pkg::rsc_sfr_req_t sfr_req_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sys_reset_o,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    input wire logic supply_monitor_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic rd_ff;
    logic wr_ff;
    logic wr_ef;
    assign rd_ff = sfr_req_i.rd && sfr_req_i.addr == rsc_pkg::SUPPLY_MON_CTRL_ADDR;
    assign wr_ff = sfr_req_i.wr && !sys_reset_o && sfr_req_i.addr == rsc_pkg::SUPPLY_MON_CTRL_ADDR;
    assign wr_ef = sfr_req_i.wr && !sys_reset_o && sfr_req_i.addr == rsc_pkg::RESET_CAUSE_ADDR;

    pin_hold_a: assert property (!reset_pin_n_i && !reset_pin_oe_o |=> sys_reset_o)
        else $error("low pin gave no reset");
    force_reset_a: assert property (wr_ef && sfr_req_i.wdata[4] |=> sys_reset_o)
        else $error("force write gave no reset");
    pin_undriven_a: assert property (wr_ef && sfr_req_i.wdata[4] |=> !reset_pin_oe_o[*8])
        else $error("pin driven on forced reset");
    unused_zero_a: assert property (rd_ff |=> sfr_rdata_o[5:0] == 6'h00)
        else $error("unused control bits not zero");
    status_live_a: assert property (rd_ff |=> sfr_rdata_o[6] == $past(supply_above_i))
        else $error("status bit not live");
    enable_write_a: assert property (wr_ff |=> supply_monitor_enable_o == $past(sfr_req_i.wdata[7]))
        else $error("monitor enable not written");
    enable_kept_a: assert property (sys_reset_o && !$past(rst_i) |=> $stable(supply_monitor_enable_o))
        else $error("monitor enable changed by reset");
    hold_min_a: assert property ($rose(sys_reset_o) |-> sys_reset_o[*8])
        else $error("reset pulse too short");

    cover property ($rose(sys_reset_o));
    cover property (rd_ff);
    cover property (!reset_pin_n_i && !sys_reset_o);
endmodule
bind rsc_reset_source_controller rsc_reset_source_controller_chk #(
    .CLOCK_LOSS_CYCLES(CLOCK_LOSS_CYCLES),
    .WDT_LIMIT(WDT_LIMIT)
) rsc_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
    .supply_above_i(supply_above_i), .comparator_out_i(comparator_out_i),
    .monitored_clock_i(monitored_clock_i), .wdt_kick_i(wdt_kick_i),
    .wdt_disable_i(wdt_disable_i), .flash_req_i(flash_req_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .sys_reset_o(sys_reset_o), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_o(reset_pin_oe_o), .supply_monitor_enable_o(supply_monitor_enable_o)
);
`default_nettype wire

// ### testbench/rsc_reset_source_controller_tb_top.sv
// self-checking testbench of the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pull_low = 1'b0;
    logic pin_n;
    logic supply = 1'b1;
    logic comp = 1'b1;
    logic mon = 1'b0;
    logic mon_run = 1'b1;
    logic kick = 1'b0;
    logic kick_en = 1'b1;
    logic wdt_dis = 1'b0;
    logic [7:0] kcnt = 8'h00;
    rsc_pkg::rsc_flash_req_t flash = '0;
    rsc_pkg::rsc_sfr_req_t sfr = '0;
    logic [7:0] rdata;
    logic sys_rst;
    logic pin_o;
    logic pin_oe;
    logic mon_en;
    int failures = 0;
    int samples_checked = 0;
    int n;

    always #2.5 clk_i = ~clk_i;

    // kicks every 8 cycles, well inside the shortened watchdog span
    always @(negedge clk_i)
    begin
        kcnt <= kcnt + 8'h01;
        kick <= kick_en && kcnt[2:0] == 3'h0;
        mon <= mon_run ? !mon : mon;
    end

    rsc_pin_drv rsc_pin_drv_i (.pull_low_i(pull_low), .dev_oe_i(pin_oe), .dev_val_i(pin_o),
        .level_o(pin_n));
    rsc_reset_source_controller #(.CLOCK_LOSS_CYCLES(20), .WDT_LIMIT(4))
        rsc_reset_source_controller_i (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
        .supply_above_i(supply), .comparator_out_i(comp), .monitored_clock_i(mon),
        .wdt_kick_i(kick), .wdt_disable_i(wdt_dis), .flash_req_i(flash), .sfr_req_i(sfr),
        .sfr_rdata_o(rdata), .sys_reset_o(sys_rst), .reset_pin_o(pin_o),
        .reset_pin_oe_o(pin_oe), .supply_monitor_enable_o(mon_en));

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr.wr = 1'b1;
        sfr.addr = a;
        sfr.wdata = d;
        @(negedge clk_i);
        sfr.wr = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
        sfr.rd = 1'b1;
        sfr.addr = a;
        @(negedge clk_i);
        sfr.rd = 1'b0;
        chk(rdata === e, "read data");
        @(negedge clk_i);
    endtask

    task automatic wait_sys(input logic v);
        n = 0;
        while (sys_rst !== v && n < 500)
        begin
            @(negedge clk_i);
            n++;
        end
        chk(n < 500, "reset level not reached");
    endtask

    task automatic quiet(input int c);
        logic hit;
        hit = 1'b0;
        repeat (c)
        begin
            @(negedge clk_i);
            hit = hit | (sys_rst !== 1'b0);
        end
        chk(!hit, "unexpected reset");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #100us;
        failures++;
        $display("mismatch at %0t: run hung", $time);
        wrap_up();
    end

    initial
    begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h02);
        sfr_rd(8'hff, 8'hc0);
        chk(mon_en === 1'b1, "monitor enable output");
        sfr_rd(8'h10, 8'h00);
        sfr_wr(8'hef, 8'h00);
        supply = 1'b0;
        quiet(30);
        sfr_rd(8'hff, 8'h80);
        supply = 1'b1;
        sfr_wr(8'hff, 8'h3f);
        sfr_rd(8'hff, 8'h40);
        sfr_wr(8'hef, 8'h10);
        chk(sys_rst === 1'b1 && pin_oe === 1'b0, "forced reset");
        wait_sys(1'b0);
        sfr_rd(8'hff, 8'h40);
        chk(mon_en === 1'b0, "monitor enable output");
        sfr_rd(8'hef, 8'h10);
        // monitor enabled and settled before it is selected
        sfr_wr(8'hff, 8'h80);
        repeat (10) @(negedge clk_i);
        sfr_wr(8'hef, 8'h02);
        supply = 1'b0;
        wait_sys(1'b1);
        @(negedge clk_i);
        chk(pin_oe === 1'b1 && pin_n === 1'b0, "pin not driven");
        supply = 1'b1;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h02);
        $display("test supply done");
        pull_low = 1'b1;
        wait_sys(1'b1);
        repeat (30) @(negedge clk_i);
        chk(sys_rst === 1'b1, "left reset with pin low");
        pull_low = 1'b0;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h01);
        $display("test pin done");
        // comparator output already settled high before enabling
        sfr_wr(8'hef, 8'h20);
        comp = 1'b0;
        wait_sys(1'b1);
        chk(pin_oe === 1'b0, "pin driven");
        repeat (30) @(negedge clk_i);
        chk(sys_rst === 1'b1, "left reset with comparator low");
        comp = 1'b1;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h20);
        comp = 1'b0;
        quiet(30);
        comp = 1'b1;
        $display("test comparator done");
        sfr_wr(8'hef, 8'h04);
        sfr_wr(8'hef, 8'h00);
        mon_run = 1'b0;
        quiet(60);
        mon_run = 1'b1;
        sfr_wr(8'hef, 8'h04);
        mon_run = 1'b0;
        quiet(18);
        wait_sys(1'b1);
        mon_run = 1'b1;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h04);
        $display("test clock loss done");
        kick_en = 1'b0;
        quiet(28);
        wait_sys(1'b1);
        kick_en = 1'b1;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h08);
        wdt_dis = 1'b1;
        @(negedge clk_i);
        wdt_dis = 1'b0;
        kick_en = 1'b0;
        quiet(120);
        sfr_wr(8'hef, 8'h10);
        wait_sys(1'b0);
        wait_sys(1'b1);
        kick_en = 1'b1;
        wait_sys(1'b0);
        sfr_rd(8'hef, 8'h08);
        $display("test watchdog done");
        for (int i = 0; i < 6; i++)
        begin
            flash.program_store_write_enable = (i == 0);
            flash.data_space_move_wr = (i < 2);
            flash.data_space_addr = 16'h3e00;
            flash.code_space_read = (i == 2 || i == 3);
            flash.code_space_addr = (i == 3) ? 16'h3dff : 16'h3e00;
            flash.fetch = (i == 4);
            flash.fetch_addr = 16'h3e00;
            flash.security_violation = (i == 5);
            @(negedge clk_i);
            flash = '0;
            if (i == 1 || i == 3)
                quiet(30);
            else
            begin
                wait_sys(1'b1);
                chk(pin_oe === 1'b0, "pin driven");
                wait_sys(1'b0);
                sfr_rd(8'hef, 8'h40);
            end
        end
        $display("test flash done");
        wrap_up();
    end
endmodule
`default_nettype wire
